// [rtl/ilm_channel.sv]
// One lamp supervision channel: failure count and lamp-healthy flag
`timescale 1ns/10ps
module ilm_channel
  import ilm_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Control from the unit
  input  wire logic enable,
  input  wire logic drive_on,
  input  wire logic replaced,
  input  wire logic tick,
  // Synchronised comparator results
  input  wire logic above_low,
  input  wire logic above_high,
  // Status
  output logic      ok
);

  typedef struct packed {
    logic [1:0] fail_cnt;
    logic       ok;
  } ilm_chan_t;

  ilm_chan_t s_q;
  ilm_chan_t s_d;

  // Next state of the channel
  always_comb begin
    s_d = s_q;
    if (!enable) begin
      s_d.fail_cnt = ILM_FAIL_ZERO;            // [RQ2]
      s_d.ok       = ILM_OK_RESET;
    end else if (drive_on) begin
      if (tick) begin                          // [RQ7]
        if (!above_low) begin                  // [RQ3]
          if (s_q.fail_cnt == ILM_FAIL_LIMIT - 2'h1) begin
            s_d.fail_cnt = ILM_FAIL_LIMIT;
            s_d.ok       = 1'h0;               // [RQ8]
          end else if (s_q.fail_cnt < ILM_FAIL_LIMIT) begin
            s_d.fail_cnt = s_q.fail_cnt + 2'h1;
          end
        end else if (above_high) begin         // [RQ4]
          s_d.fail_cnt = ILM_FAIL_ZERO;
          s_d.ok       = 1'h1;
        end
        // Between thresholds nothing moves, giving hysteresis [RQ10]
      end
    end else begin
      // Output off: no new fault, a replacement or healthy upper comparator releases one [RQ5] [RQ6]
      if (replaced || above_high) begin        // [RQ9] [RQ11]
        s_d.fail_cnt = ILM_FAIL_ZERO;
        s_d.ok       = 1'h1;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '{fail_cnt: ILM_FAIL_ZERO, ok: ILM_OK_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign ok = s_q.ok;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_eval_fail;
    enable && drive_on && tick && !above_low;
  endsequence

  sequence s_eval_pass;
    enable && drive_on && tick && above_high;
  endsequence

  a_second_fail_drops: assert property (s_eval_fail ##0 (s_q.fail_cnt == 2'h1) |=> !ok) // [RQ8]
    else $error("second failing check did not clear status");
  a_first_fail_keeps: assert property (s_eval_fail ##0 (s_q.fail_cnt == 2'h0)
    |=> (ok == $past(ok)) && (s_q.fail_cnt == 2'h1)) // [RQ8]
    else $error("single failing check changed status");
  a_pass_sets_ok: assert property (s_eval_pass |=> ok && (s_q.fail_cnt == 2'h0)) // [RQ4]
    else $error("healthy current did not set status");
  a_mid_holds: assert property (enable && drive_on && tick && above_low && !above_high
    |=> $stable(s_q)) // [RQ10]
    else $error("mid-range current changed state");
  a_no_tick_holds: assert property (enable && drive_on && !tick |=> $stable(s_q)) // [RQ7]
    else $error("state moved between checks");
  a_off_latched: assert property (enable && !drive_on && !replaced && !above_high
    |=> $stable(s_q)) // [RQ5]
    else $error("state moved while output off");
  a_replace_release: assert property (enable && !drive_on && replaced |=> ok) // [RQ9]
    else $error("replacement did not restore status");
  a_mode_gate: assert property (!enable |=> ok && (s_q.fail_cnt == 2'h0)) // [RQ2]
    else $error("unconfigured terminal not idle");
  a_fault_persists: assert property (!ok && !drive_on && !replaced && !above_high && enable // [RQ6]
    |=> !ok)
    else $error("latched fault lost while output off");

endmodule : ilm_channel

// [rtl/ilm_monitor.sv]
// Indicator lamp break monitor for the two lamp-capable test terminals
// How it works
// RQ1: Lamp supervision exists only on test_terminal_three and test_terminal_seven.
// RQ2: A terminal is supervised only while its output mode is set to the lamp setting.
// RQ3: Current below the lower comparator counts as a lamp failure or wire break.
// RQ4: Current at or above the upper comparator is healthy and sets the status to 1.
// RQ5: While the lamp drive is off no failure evaluation is done.
// RQ6: A fault confirmed while driving stays latched after the drive turns off.
// RQ7: Disconnection is checked once per 3 s check cycle, not on every clock.
// RQ8: The status clears only after two consecutive failing checks.
// RQ9: After replacement the status returns to 1 even with the drive off.
// RQ10: Current between the thresholds leaves the count and the status unchanged.
// RQ11: The unit supplies a replacement indication or a healthy probe to release a fault.
`timescale 1ns/10ps
module ilm_monitor
  import ilm_pkg::*;
#(
  parameter int unsigned CHECK_CYCLES = ILM_CHECK_CYCLES
)(
  // Clock and reset
  input  wire logic                        CLK_SYS,
  input  wire logic                        RESET,
  // Terminal configuration from the unit
  input  wire logic [ILM_TERMS-1:0][1:0]   TERM_MODE,
  // Lamp drive and replacement per lamp terminal, index 0 is terminal three
  input  wire logic [ILM_LAMPS-1:0]        LAMP_DRIVE,
  input  wire logic [ILM_LAMPS-1:0]        LAMP_REPLACED,
  // Current comparators, asynchronous pins
  input  wire logic [ILM_LAMPS-1:0]        CUR_ABOVE_LOW,
  input  wire logic [ILM_LAMPS-1:0]        CUR_ABOVE_HIGH,
  // Status toward cyclic I/O data
  output logic      [ILM_LAMPS-1:0]        LAMP_OK,
  output logic                             CHECK_TICK
);

  typedef struct packed {
    logic [ILM_TIMER_W-1:0] timer;
    logic                   tick;
    logic [ILM_LAMPS-1:0]   low_m;
    logic [ILM_LAMPS-1:0]   low_s;
    logic [ILM_LAMPS-1:0]   high_m;
    logic [ILM_LAMPS-1:0]   high_s;
  } ilm_top_t;

  localparam logic [ILM_TIMER_W-1:0] TIMER_LAST = ILM_TIMER_W'(CHECK_CYCLES - 1);

  ilm_top_t s_q;
  ilm_top_t s_d;
  logic [ILM_LAMPS-1:0] ok_w;
  logic [ILM_LAMPS-1:0] en_w;

  // Check cycle timer and comparator synchronisers
  always_comb begin
    s_d        = s_q;
    s_d.tick   = 1'h0;
    s_d.low_m  = CUR_ABOVE_LOW;
    s_d.low_s  = s_q.low_m;
    s_d.high_m = CUR_ABOVE_HIGH;
    s_d.high_s = s_q.high_m;
    // A long period keeps brief flicker from counting as a break
    if (s_q.timer == TIMER_LAST) begin         // [RQ7]
      s_d.timer = '0;
      s_d.tick  = 1'h1;
    end else begin
      s_d.timer = s_q.timer + ILM_TIMER_W'(1);
    end
  end

  // State register
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // One channel per lamp-capable terminal; other terminals have no monitor
  for (genvar g = 0; g < ILM_LAMPS; g++) begin : g_lamp
    assign en_w[g] = (TERM_MODE[ILM_LAMP_TERM[g]] == ILM_MODE_LAMP); // [RQ1] [RQ2]
    ilm_channel u_chan (
      .clk        (CLK_SYS),
      .reset      (RESET),
      .enable     (en_w[g]),
      .drive_on   (LAMP_DRIVE[g]),
      .replaced   (LAMP_REPLACED[g]),          // [RQ11]
      .tick       (s_q.tick),
      .above_low  (s_q.low_s[g]),
      .above_high (s_q.high_s[g]),
      .ok         (ok_w[g])
    );
  end

  // Both outputs come straight from flip-flops
  assign LAMP_OK    = ok_w;
  assign CHECK_TICK = s_q.tick;

  // All checks below run on the system clock and rest during reset
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  // The tick is the only evaluation strobe the channels see, so its
  // placement and width are pinned down first
  a_tick_restart: assert property (s_q.tick |-> s_q.timer == '0) // [RQ7]
    else $error("tick not aligned with timer restart");
  a_tick_single: assert property (s_q.tick |=> !s_q.tick) // [RQ7]
    else $error("tick lasted more than one cycle");
  a_tick_cause: assert property ((s_q.timer == TIMER_LAST) |=> s_q.tick) // [RQ7]
    else $error("timer end gave no tick");

  // No tick anywhere but at the end of a count
  a_tick_only_end: assert property ((s_q.timer != TIMER_LAST) |=> !s_q.tick) // [RQ7]
    else $error("tick away from timer end");

  // Timer climbs by one until it wraps; a skipped count would shorten
  // the period and let a brief dropout count twice
  a_timer_step: assert property ((s_q.timer != TIMER_LAST) // [RQ7]
    |=> s_q.timer == $past(s_q.timer) + ILM_TIMER_W'(1))
    else $error("timer skipped a count");

  // The timer never leaves its range, so the period is never stretched
  a_timer_range: assert property (s_q.timer <= TIMER_LAST) // [RQ7]
    else $error("timer out of range");

  // Reset leaves both lamps healthy and the period starting afresh
  a_reset_healthy: assert property ($past(RESET) |-> LAMP_OK == '1) // [RQ4]
    else $error("status not healthy after reset");
  a_reset_idle: assert property ($past(RESET) |-> !CHECK_TICK && (s_q.timer == '0)) // [RQ7]
    else $error("timer not idle after reset");

  // Both comparator pins pass exactly two stages; the guard skips the
  // edges at which a stage still holds its reset value
  a_sync_delay: assert property (!$past(RESET) && !$past(RESET, 2) // [RQ3]
    |-> s_q.low_s == $past(CUR_ABOVE_LOW, 2))
    else $error("low comparator not two stages");
  a_sync_high: assert property (!$past(RESET) && !$past(RESET, 2) // [RQ4]
    |-> s_q.high_s == $past(CUR_ABOVE_HIGH, 2))
    else $error("high comparator not two stages");

  // A terminal outside the lamp setting always reads healthy, so a
  // stale count can never leak out after a mode change
  a_term_three: assert property ((TERM_MODE[ILM_LAMP_TERM[0]] != ILM_MODE_LAMP) // [RQ1]
    |=> LAMP_OK[0])
    else $error("terminal three monitored without lamp mode");
  a_term_seven: assert property ((TERM_MODE[ILM_LAMP_TERM[1]] != ILM_MODE_LAMP) // [RQ1]
    |=> LAMP_OK[1])
    else $error("terminal seven monitored without lamp mode");

  // Per-lamp status checks seen from the pins of this block; they
  // complement the checks inside each channel, which watch the count
  for (genvar k = 0; k < ILM_LAMPS; k++) begin : g_chk

    // One evaluation point of this lamp
    sequence s_lamp_eval;
      en_w[k] && LAMP_DRIVE[k] && s_q.tick;
    endsequence

    // An evaluation point at which the lamp current reads healthy
    sequence s_lamp_high;
      s_lamp_eval ##0 s_q.high_s[k];
    endsequence

    // An evaluation point with current between the two trip points
    sequence s_lamp_mid;
      s_lamp_eval ##0 (s_q.low_s[k] && !s_q.high_s[k]);
    endsequence

    // The status can only drop on a check pulse
    a_drop_on_tick: assert property (LAMP_OK[k] && !s_q.tick |=> LAMP_OK[k]) // [RQ7]
      else $error("status dropped between checks");

    // The status can only drop when the lower comparator reads low
    a_drop_needs_low: assert property (LAMP_OK[k] && s_q.low_s[k] |=> LAMP_OK[k]) // [RQ3]
      else $error("status dropped with current present");

    // With the drive off no fresh fault can appear
    a_off_no_fault: assert property (LAMP_OK[k] && !LAMP_DRIVE[k] |=> LAMP_OK[k]) // [RQ5]
      else $error("fault raised while drive off");

    // Healthy current on a check always restores the status
    a_high_restores: assert property (s_lamp_high |=> LAMP_OK[k]) // [RQ4]
      else $error("healthy check left status low");

    // Mid-range current leaves the status where it was
    a_mid_no_change: assert property (s_lamp_mid |=> LAMP_OK[k] == $past(LAMP_OK[k])) // [RQ10]
      else $error("mid-range check moved status");

    // A confirmed fault survives the drive turning off
    a_fault_holds_off: assert property (en_w[k] && !LAMP_OK[k] && !LAMP_DRIVE[k] // [RQ6]
      && !LAMP_REPLACED[k] && !s_q.high_s[k] |=> !LAMP_OK[k])
      else $error("fault released without replacement");

    // Replacement with the drive off releases the fault at once
    a_replace_off: assert property (en_w[k] && !LAMP_DRIVE[k] && LAMP_REPLACED[k] // [RQ9]
      |=> LAMP_OK[k])
      else $error("replacement ignored with drive off");

    // With the drive on in the lamp setting, only a healthy check may release a fault, so a
    // stuck replacement line cannot mask a dead lamp
    a_replace_ignored: assert property (en_w[k] && LAMP_DRIVE[k] && LAMP_REPLACED[k] // [RQ11]
      && !LAMP_OK[k] && !s_q.tick |=> !LAMP_OK[k])
      else $error("replacement released fault with drive on");

    // Leaving the lamp setting forces the status healthy
    a_mode_healthy: assert property (!en_w[k] |=> LAMP_OK[k]) // [RQ2]
      else $error("unsupervised lamp reported fault");

  end

endmodule : ilm_monitor

// [rtl/ilm_pkg.sv]
// Shared constants and types for the indicator lamp break monitor
package ilm_pkg;

  // Clock and check cycle timing
  localparam int unsigned ILM_CLK_HZ       = 100_000_000;
  localparam int unsigned ILM_CHECK_MS     = 3000;
  localparam int unsigned ILM_CHECK_CYCLES = ILM_CHECK_MS * (ILM_CLK_HZ / 1000);
  localparam int unsigned ILM_TIMER_W      = 32;

  // Comparator trip points, set by the analog front end
  localparam int unsigned ILM_LOW_MA  = 5;
  localparam int unsigned ILM_HIGH_MA = 25;

  // Terminal layout: only two terminals may carry a lamp
  localparam int ILM_TERMS                  = 12;
  localparam int ILM_LAMPS                  = 2;
  localparam int ILM_LAMP_TERM [ILM_LAMPS]  = '{3, 7};

  // Consecutive failing checks before the status drops
  localparam logic [1:0] ILM_FAIL_LIMIT = 2'h2;
  localparam logic [1:0] ILM_FAIL_ZERO  = 2'h0;
  localparam logic       ILM_OK_RESET   = 1'h1;

  // Test terminal output mode
  typedef enum logic [1:0] {
    ILM_MODE_NOT_USED = 2'h0,
    ILM_MODE_TEST_OUT = 2'h1,
    ILM_MODE_POWER    = 2'h2,
    ILM_MODE_LAMP     = 2'h3
  } ilm_mode_t;

endpackage : ilm_pkg

// [sim/ilm_lamp_model.sv]
// Lamp and current comparator model for both lamp terminals
`timescale 1ns/10ps
module ilm_lamp_model
  import ilm_pkg::*;
(
  // Drive and set lamp current in mA
  input  wire logic [ILM_LAMPS-1:0]      drive,
  input  wire logic [ILM_LAMPS-1:0][7:0] lamp_ma,
  // Comparator pins
  output logic      [ILM_LAMPS-1:0]      above_low,
  output logic      [ILM_LAMPS-1:0]      above_high
);
  // No drive means no current, so a dark lamp never looks healthy
  always_comb begin
    for (int i = 0; i < ILM_LAMPS; i++) begin
      above_low[i]  = drive[i] && (lamp_ma[i] >= ILM_LOW_MA);
      above_high[i] = drive[i] && (lamp_ma[i] >= ILM_HIGH_MA);
    end
  end
endmodule : ilm_lamp_model

// [sim/tb_indicator_lamp_break_monitor.sv]
// Self-checking bench for the indicator lamp break monitor
`timescale 1ns/10ps
module tb_indicator_lamp_break_monitor;
  import ilm_pkg::*;
  localparam int unsigned CYC = 16;
  logic                      clk_sys;
  logic                      reset;
  logic [ILM_TERMS-1:0][1:0] term_mode;
  logic [1:0]                drive, replaced, a_low, a_high, lamp_ok, f;
  logic [1:0][7:0]           ma;
  logic                      check_tick, chk;
  logic [31:0]               exp_q [$];
  int                        mismatches, tests_run, gap;

  // Free-running 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  ilm_monitor #(.CHECK_CYCLES(CYC)) i_ilm_monitor (.CLK_SYS(clk_sys), .RESET(reset),
    .TERM_MODE(term_mode), .LAMP_DRIVE(drive), .LAMP_REPLACED(replaced),
    .CUR_ABOVE_LOW(a_low), .CUR_ABOVE_HIGH(a_high), .LAMP_OK(lamp_ok),
    .CHECK_TICK(check_tick));
  ilm_lamp_model i_ilm_lamp_model (.drive(drive), .lamp_ma(ma), .above_low(a_low),
    .above_high(a_high));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // Note an expected status; the watcher compares it at the next edge
  task automatic expect_ok(input logic [1:0] v);
    exp_q.push_back({30'h0, v});
    chk = 1'b1;
    @(negedge clk_sys);
    chk = 1'b0;
  endtask : expect_ok

  // Watcher reads the pre-edge value, which is what the driver saw
  always @(posedge clk_sys) begin
    if (chk === 1'b1) check("lamp_ok", {30'h0, lamp_ok}, exp_q.pop_front());
  end

  // Wait past n check pulses so the evaluated status has landed
  task automatic tick(input int n);
    repeat (n) begin
      do @(negedge clk_sys); while (check_tick !== 1'b1);
      @(negedge clk_sys);
    end
  endtask : tick

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // Watchdog sized for roughly forty check periods
  initial begin
    #(CYC * 10 * 40);
    mismatches++;
    $display("watchdog expired");
    report_and_stop;
  end

  // Main sequence
  initial begin
    void'($urandom(11769));
    reset = 1'b1;
    chk = 1'b0;
    term_mode = {ILM_TERMS{ILM_MODE_LAMP}};
    drive = 2'h3;
    replaced = 2'h0;
    ma = {8'h1E, 8'h1E};
    repeat (3) @(negedge clk_sys);
    reset = 1'b0;
    tick(1);
    expect_ok(2'h3);
    for (int i = 0; i < 2; i++) begin
      f = ~(2'h1 << i);
      ma[i] = 8'($urandom_range(4, 0));
      tick(1);
      expect_ok(2'h3);
      ma[i] = 8'($urandom_range(24, 5));
      tick(1);
      expect_ok(2'h3);
      ma[i] = 8'h00;
      tick(1);
      expect_ok(f);
      drive[i] = 1'b0;
      tick(1);
      expect_ok(f);
      drive[i] = 1'b1;
      replaced[i] = 1'b1;
      repeat (2) @(negedge clk_sys);
      expect_ok(f);
      drive[i] = 1'b0;
      repeat (2) @(negedge clk_sys);
      replaced[i] = 1'b0;
      expect_ok(2'h3);
      drive[i] = 1'b1;
      ma[i] = 8'($urandom_range(60, 25));
      tick(1);
      $display("lamp %0d fault and replacement test done", i);
    end
    // One failing check, then a pass, then a failure again
    ma[0] = 8'h00;
    tick(1);
    ma[0] = 8'h1E;
    tick(1);
    ma[0] = 8'h00;
    tick(1);
    expect_ok(2'h3);
    drive = 2'h0;
    ma = 16'h0;
    tick(2);
    expect_ok(2'h3);
    $display("hysteresis and drive-off test done");
    drive = 2'h3;
    term_mode[3] = 2'($urandom_range(2, 0));
    term_mode[7] = 2'($urandom_range(2, 0));
    tick(2);
    expect_ok(2'h3);
    // Align on one pulse, then count edges to the next one
    do @(negedge clk_sys); while (check_tick !== 1'b1);
    gap = 0;
    do begin
      @(negedge clk_sys);
      gap++;
    end while (check_tick !== 1'b1);
    check("check spacing", 32'(gap), 32'(CYC));
    $display("mode and spacing test done");
    report_and_stop;
  end
endmodule : tb_indicator_lamp_break_monitor
